/* File: pin_sync.sv */
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic [W-1:0] pin_i,
  output logic [W-1:0] level_o
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] s2_ff;
  logic [W-1:0] s3_ff;

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      meta_ff <= INIT;
      s2_ff <= INIT;
      s3_ff <= INIT;
    end else begin
      meta_ff <= pin_i;
      s2_ff <= meta_ff;
      s3_ff <= s2_ff;
    end
  end

  // a bit moves only once the last two stages agree
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      level_o <= INIT;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (s2_ff[i] == s3_ff[i]) begin
          level_o[i] <= s3_ff[i];
        end
      end
    end
  end
endmodule

/* File: sec_fault_pkg.sv */
// shared constants and carriers of the secondary fault block
package sec_fault_pkg;
  // serial frame layout
  localparam int FRAME_BITS = 24;
  localparam int ADDR_W = 5;
  localparam int DATA_W = 10;
  localparam int RW_POS = 23;
  localparam int ADDR_LSB = 18;
  localparam int DATA_LSB = 8;
  localparam int CHECK_W = 8;
  // register offsets
  localparam logic [4:0] FLAGS_ADDR = 5'h0E;
  localparam logic [4:0] ENABLES_ADDR = 5'h0F;
  localparam logic [4:0] ROUTING_ADDR = 5'h10;
  localparam logic [4:0] SELF_TEST_ADDR = 5'h1C;
  // fault bit positions
  localparam int SELF_TEST_BIT = 9;
  localparam int LOGIC_SUPPLY_BIT = 8;
  localparam int DEADTIME_BIT = 7;
  localparam int SERIAL_BIT = 6;
  localparam int CFG_CRC_BIT = 5;
  localparam int GATE_MON_BIT = 4;
  localparam int WATCHDOG_BIT = 3;
  localparam int LINK_ERR_BIT = 2;
  localparam int REFERENCE_BIT = 1;
  localparam int NEG_SUPPLY_BIT = 0;
  // reset values and bit classes
  localparam logic [9:0] FLAGS_RESET = 10'h000;
  localparam logic [9:0] ENABLES_RESET = 10'h0EC;
  localparam logic [9:0] ENABLES_WRITABLE = 10'h0FD;
  localparam logic [9:0] ALWAYS_ENABLED = 10'h302;
  localparam logic [9:0] ROUTING_RESET = 10'h002;
  localparam logic [9:0] ROUTING_WRITABLE = 10'h083;
  localparam logic [9:0] SHUTDOWN_FAULTS = 10'h33F;
  localparam logic [9:0] SELF_TEST_RESET = 10'h000;
  // timing counts in clock cycles
  localparam int CONV_PERIOD_CYC = 1000;
  localparam int REPLY_TIMEOUT_CYC = 250;

  // raw fault conditions, all from outside the clock domain
  typedef struct packed {
    logic logic_supply;
    logic deadtime;
    logic cfg_crc_lv;
    logic cfg_crc_hv;
    logic gate_mismatch;
    logic hv_watchdog;
    logic link_crc;
    logic link_framing;
    logic reference;
    logic neg_supply;
    logic link_reply;
  } fault_in_s;

  // serial pins of the register port
  typedef struct packed {
    logic chip_select_n;
    logic sclk;
    logic mosi;
  } serial_in_s;

  // self test completion from on-chip logic
  typedef struct packed {
    logic done;
    logic [DATA_W-1:0] result;
  } self_test_s;
endpackage

/* File: sec_fault_sva.sv */
// assertions on the secondary fault block ports
`timescale 1ns/1ps
module sec_fault_sva
  import sec_fault_pkg::*;
#(
  parameter int CONV_PERIOD = CONV_PERIOD_CYC
) (
  input wire logic clock_i,
  input wire logic srst_i,
  input wire self_test_s self_test_i,
  input wire logic active_clamp_enable_i,
  input wire logic switching_enable_o,
  input wire logic low_side_gate_command_o,
  input wire logic active_clamp_o,
  input wire logic primary_fault_pin_n_o,
  input wire logic alternate_report_pin_n_o,
  input wire logic conversion_request_o,
  input wire logic [DATA_W-1:0] self_test_detail_o
);
  int gap_ff;
  logic seen_ff;
  default clocking @(posedge clock_i);
  endclocking
  default disable iff (srst_i);
  // ------
  // cycles since the last request; first one after reset is not timed
  // ------
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      gap_ff <= 0;
      seen_ff <= 1'h0;
    end else begin
      gap_ff <= conversion_request_o ? 1 : gap_ff + 1;
      seen_ff <= seen_ff | conversion_request_o;
    end
  end
  chk_reset_rest: assert property (
    $fell(srst_i) |-> switching_enable_o && !low_side_gate_command_o &&
    primary_fault_pin_n_o && alternate_report_pin_n_o)
    else $error("outputs not at rest after reset");
  chk_gate_switch: assert property (
    low_side_gate_command_o != switching_enable_o)
    else $error("gate command and switching disagree");
  chk_clamp_gate: assert property (
    active_clamp_o |-> low_side_gate_command_o)
    else $error("clamp on while switching allowed");
  chk_clamp_off: assert property (
    (!active_clamp_enable_i) [*3] |-> !active_clamp_o)
    else $error("clamp on while not enabled");
  chk_conv_gap: assert property (
    conversion_request_o && seen_ff |-> gap_ff == CONV_PERIOD)
    else $error("request spacing wrong");
  chk_conv_alive: assert property (
    seen_ff |-> gap_ff <= CONV_PERIOD)
    else $error("periodic request missing");
  chk_detail_load: assert property (
    self_test_i.done |=> self_test_detail_o == $past(self_test_i.result))
    else $error("self test detail not loaded");
  chk_detail_hold: assert property (
    !self_test_i.done |=> $stable(self_test_detail_o))
    else $error("self test detail changed");
  chk_self_trip: assert property (
    self_test_i.done && self_test_i.result != '0 |-> ##[1:3]
    !switching_enable_o)
    else $error("failed self test did not stop switching");
  chk_self_report: assert property (
    self_test_i.done && self_test_i.result != '0 |-> ##[1:3]
    !primary_fault_pin_n_o)
    else $error("failed self test not reported");
  cover property (self_test_i.done && self_test_i.result != '0);
  cover property (!switching_enable_o && !alternate_report_pin_n_o);
  cover property (switching_enable_o && !primary_fault_pin_n_o);
endmodule
bind secondary_fault_status_mask sec_fault_sva #(.CONV_PERIOD(CONV_PERIOD))
  sec_fault_sva_inst (.clock_i, .srst_i, .self_test_i, .active_clamp_enable_i,
  .switching_enable_o, .low_side_gate_command_o, .active_clamp_o,
  .primary_fault_pin_n_o, .alternate_report_pin_n_o, .conversion_request_o,
  .self_test_detail_o);

/* File: secondary_fault_status_mask.sv */
// secondary fault flags, enables, routing and serial register port
`timescale 1ns/1ps
module secondary_fault_status_mask
  import sec_fault_pkg::*;
#(
  parameter int CONV_PERIOD = CONV_PERIOD_CYC,
  parameter int REPLY_TIMEOUT = REPLY_TIMEOUT_CYC
) (
  input wire logic clock_i,
  input wire logic srst_i,
  input wire serial_in_s serial_i,
  input wire fault_in_s fault_i,
  input wire self_test_s self_test_i,
  input wire logic config_mode_i,
  input wire logic power_up_i,
  input wire logic monitor_source_select_i,
  input wire logic active_clamp_enable_i,
  output logic miso_o,
  output logic miso_oe_o,
  output logic switching_enable_o,
  output logic low_side_gate_command_o,
  output logic active_clamp_o,
  output logic primary_fault_pin_n_o,
  output logic alternate_report_pin_n_o,
  output logic conversion_request_o,
  output logic [DATA_W-1:0] self_test_detail_o
);

  // ------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------
  serial_in_s ser;
  fault_in_s flt;

  pin_sync #(
    .W($bits(serial_in_s)),
    .INIT(3'h4)
  ) u_serial_sync (
    .clock_i(clock_i),
    .srst_i(srst_i),
    .pin_i(serial_i),
    .level_o(ser)
  );

  pin_sync #(
    .W($bits(fault_in_s)),
    .INIT(11'h000)
  ) u_fault_sync (
    .clock_i(clock_i),
    .srst_i(srst_i),
    .pin_i(fault_i),
    .level_o(flt)
  );

  // ------------------------------------------------------------
  // edge detection on filtered levels
  // ------------------------------------------------------------
  logic sclk_prev_ff;
  logic cs_n_prev_ff;
  logic reply_prev_ff;
  logic sclk_rise;
  logic sclk_fall;
  logic frame_start;
  logic frame_end;
  logic reply_rise;

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      sclk_prev_ff <= 1'b0;
      cs_n_prev_ff <= 1'b1;
      reply_prev_ff <= 1'b0;
    end else begin
      sclk_prev_ff <= ser.sclk;
      cs_n_prev_ff <= ser.chip_select_n;
      reply_prev_ff <= flt.link_reply;
    end
  end

  assign sclk_rise = ser.sclk & ~sclk_prev_ff & ~ser.chip_select_n;
  assign sclk_fall = ~ser.sclk & sclk_prev_ff & ~ser.chip_select_n;
  assign frame_start = ~ser.chip_select_n & cs_n_prev_ff;
  assign frame_end = ser.chip_select_n & ~cs_n_prev_ff;
  assign reply_rise = flt.link_reply & ~reply_prev_ff;

  // ------------------------------------------------------------
  // serial receive
  // ------------------------------------------------------------
  logic [FRAME_BITS-1:0] rx_ff;
  logic [5:0] bit_cnt_ff;

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      rx_ff <= '0;
    end else if (sclk_rise) begin
      rx_ff <= {rx_ff[FRAME_BITS-2:0], ser.mosi};
    end
  end

  // counter saturates so that long frames stay detectable
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      bit_cnt_ff <= 6'h00;
    end else if (frame_start) begin
      bit_cnt_ff <= 6'h00;
    end else if (sclk_rise && bit_cnt_ff != 6'h3F) begin
      bit_cnt_ff <= bit_cnt_ff + 6'h01;
    end
  end

  // ------------------------------------------------------------
  // frame decode
  // ------------------------------------------------------------
  logic frame_ok;
  logic frame_bad;
  logic is_write;
  logic [ADDR_W-1:0] frame_addr;
  logic [DATA_W-1:0] frame_data;
  logic wr_flags;
  logic wr_enables;
  logic wr_routing;

  assign frame_ok = frame_end && bit_cnt_ff == 6'(FRAME_BITS);
  assign frame_bad = frame_end && bit_cnt_ff != 6'(FRAME_BITS);
  assign is_write = rx_ff[RW_POS];
  assign frame_addr = rx_ff[ADDR_LSB +: ADDR_W];
  assign frame_data = rx_ff[DATA_LSB +: DATA_W];

  function automatic logic hit(input logic ok, input logic [ADDR_W-1:0] fa, a);
    hit = ok && fa == a;
  endfunction

  assign wr_flags = hit(frame_ok && is_write, frame_addr, FLAGS_ADDR);
  assign wr_enables = hit(frame_ok && is_write, frame_addr, ENABLES_ADDR);
  assign wr_routing = hit(frame_ok && is_write, frame_addr, ROUTING_ADDR);

  // ------------------------------------------------------------
  // lv watchdog: periodic request and reply timer
  // ------------------------------------------------------------
  logic [15:0] period_cnt_ff;
  logic [15:0] reply_cnt_ff;
  logic waiting_ff;
  logic conv_due;
  logic lv_timeout;

  assign conv_due = period_cnt_ff == 16'(CONV_PERIOD - 1);
  assign lv_timeout = waiting_ff && reply_cnt_ff == 16'(REPLY_TIMEOUT - 1);

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      period_cnt_ff <= 16'h0000;
      conversion_request_o <= 1'b0;
    end else begin
      conversion_request_o <= conv_due;
      if (conv_due) begin
        period_cnt_ff <= 16'h0000;
      end else begin
        period_cnt_ff <= period_cnt_ff + 16'h0001;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      waiting_ff <= 1'b0;
      reply_cnt_ff <= 16'h0000;
    end else if (conv_due) begin
      waiting_ff <= 1'b1;
      reply_cnt_ff <= 16'h0000;
    end else if (reply_rise || lv_timeout) begin
      waiting_ff <= 1'b0;
    end else if (waiting_ff) begin
      reply_cnt_ff <= reply_cnt_ff + 16'h0001;
    end
  end

  // ------------------------------------------------------------
  // fault events
  // ------------------------------------------------------------
  logic [DATA_W-1:0] event_vec;

  always_comb begin
    event_vec = '0;
    event_vec[SELF_TEST_BIT] = self_test_i.done & (|self_test_i.result);
    // no logic supply fault in power up
    event_vec[LOGIC_SUPPLY_BIT] = flt.logic_supply & ~power_up_i;
    event_vec[DEADTIME_BIT] = flt.deadtime;
    event_vec[SERIAL_BIT] = frame_bad;
    event_vec[CFG_CRC_BIT] = flt.cfg_crc_lv | flt.cfg_crc_hv;
    event_vec[GATE_MON_BIT] = flt.gate_mismatch & ~monitor_source_select_i;
    event_vec[WATCHDOG_BIT] = flt.hv_watchdog | lv_timeout;
    event_vec[LINK_ERR_BIT] = flt.link_crc | flt.link_framing;
    // no reference fault in power up
    event_vec[REFERENCE_BIT] = flt.reference & ~power_up_i;
    event_vec[NEG_SUPPLY_BIT] = flt.neg_supply;
  end

  // ------------------------------------------------------------
  // enables, routing, flags
  // ------------------------------------------------------------
  logic [DATA_W-1:0] enables_ff;
  logic [DATA_W-1:0] routing_ff;
  logic [DATA_W-1:0] flags_ff;
  logic [DATA_W-1:0] nxt_flags;
  logic [DATA_W-1:0] active_en;
  logic [DATA_W-1:0] clear_vec;

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      enables_ff <= ENABLES_RESET;
      routing_ff <= ROUTING_RESET;
    end else if (config_mode_i) begin
      if (wr_enables) begin
        enables_ff <= frame_data & ENABLES_WRITABLE;
      end
      if (wr_routing) begin
        routing_ff <= frame_data & ROUTING_WRITABLE;
      end
    end
  end

  assign active_en = enables_ff | ALWAYS_ENABLED;
  assign clear_vec = wr_flags ? frame_data : '0;

  // set wins over a clear in the same cycle
  always_comb begin
    nxt_flags = flags_ff & ~clear_vec;
    nxt_flags = nxt_flags | (event_vec & active_en);
  end

  // latch and hold, zero at reset
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      flags_ff <= FLAGS_RESET;
    end else begin
      flags_ff <= nxt_flags;
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      self_test_detail_o <= SELF_TEST_RESET;
    end else if (self_test_i.done) begin
      self_test_detail_o <= self_test_i.result;
    end
  end

  // ------------------------------------------------------------
  // fault response
  // ------------------------------------------------------------
  logic shutdown;
  logic [DATA_W-1:0] pending;

  assign shutdown = |(flags_ff & SHUTDOWN_FAULTS);

  // deadtime enforcement lives in the driver path and is never
  // bypassed here, so masking that fault only hides the report
  // deadtime left untouched
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      switching_enable_o <= 1'b1;
      low_side_gate_command_o <= 1'b0;
      active_clamp_o <= 1'b0;
    end else begin
      switching_enable_o <= ~shutdown;
      low_side_gate_command_o <= shutdown;
      active_clamp_o <= shutdown & active_clamp_enable_i;
    end
  end

  // a bit disabled after latching stops being reported
  assign pending = flags_ff & active_en;

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      primary_fault_pin_n_o <= 1'b1;
      alternate_report_pin_n_o <= 1'b1;
    end else begin
      primary_fault_pin_n_o <= ~|(pending & ~routing_ff);
      alternate_report_pin_n_o <= ~|(pending & routing_ff);
    end
  end

  // ------------------------------------------------------------
  // read data and serial transmit
  // ------------------------------------------------------------
  logic [DATA_W-1:0] rd_data;
  logic [FRAME_BITS-1:0] resp_ff;
  logic [FRAME_BITS-1:0] tx_ff;

  // unmapped addresses read as zero
  always_comb begin
    case (frame_addr)
      FLAGS_ADDR: rd_data = flags_ff;
      ENABLES_ADDR: rd_data = enables_ff;
      ROUTING_ADDR: rd_data = routing_ff;
      SELF_TEST_ADDR: rd_data = self_test_detail_o;
      default: rd_data = '0;
    endcase
  end

  // the answer goes out in the following frame; check byte is zero
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      resp_ff <= '0;
    end else if (frame_ok) begin
      resp_ff <= {1'b0, frame_addr, rd_data, {CHECK_W{1'b0}}};
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      tx_ff <= '0;
      miso_o <= 1'b0;
    end else if (frame_start) begin
      tx_ff <= resp_ff;
      miso_o <= resp_ff[FRAME_BITS-1];
    end else if (sclk_fall) begin
      tx_ff <= {tx_ff[FRAME_BITS-2:0], 1'b0};
      miso_o <= tx_ff[FRAME_BITS-2];
    end
  end

  // data line is driven only inside a frame
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      miso_oe_o <= 1'b0;
    end else begin
      miso_oe_o <= ~ser.chip_select_n;
    end
  end
endmodule

/* File: secondary_fault_status_mask_tb.sv */
// self-checking bench for the secondary fault block
`timescale 1ns/1ps
module secondary_fault_status_mask_tb;
  import sec_fault_pkg::*;
  logic clock_i = 0;
  logic srst_i = 1;
  serial_in_s serial_i;
  fault_in_s flt = '0;
  self_test_s self_test_i = '0;
  logic reply = 0;
  logic config_mode_i = 0;
  logic power_up_i = 0;
  logic monitor_source_select_i = 0;
  logic active_clamp_enable_i = 1;
  logic miso_o, miso_oe_o, switching_enable_o, low_side_gate_command_o;
  logic active_clamp_o, primary_fault_pin_n_o, alternate_report_pin_n_o;
  logic conversion_request_o, rd_stb, ce, probe = 0, reply_on = 1;
  logic [9:0] self_test_detail_o, rd_data, r, det = '0;
  logic [14:0] q[$], got, exp;
  logic [23:0] rx;
  int n_errors = 0, compares = 0, cyc = 0, rep_cnt = 0;
  int sh[8] = '{0, 2, 3, 4, 5, 6, 7, 9};
  logic [9:0] fb[8] = '{10'h100, 10'h020, 10'h020, 10'h010, 10'h008,
    10'h004, 10'h004, 10'h001};
  secondary_fault_status_mask #(.CONV_PERIOD(20), .REPLY_TIMEOUT(12))
    secondary_fault_status_mask_inst (.clock_i, .srst_i, .serial_i,
    .fault_i({flt[10:1], reply}), .self_test_i, .config_mode_i, .power_up_i,
    .monitor_source_select_i, .active_clamp_enable_i, .miso_o, .miso_oe_o,
    .switching_enable_o, .low_side_gate_command_o, .active_clamp_o,
    .primary_fault_pin_n_o, .alternate_report_pin_n_o,
    .conversion_request_o, .self_test_detail_o);
  // a released data line reads as the inverse of its last level
  serial_host_model serial_host_model_inst (.clock_i,
    .miso_i(miso_oe_o ? miso_o : ~miso_o),
    .serial_o(serial_i), .rd_stb_o(rd_stb), .rd_data_o(rd_data));
  initial begin
    forever #2 clock_i = ~clock_i;
  end
  // ------
  // far side answers each request unless told to stay silent
  // ------
  always @(posedge clock_i) begin
    rep_cnt <= (conversion_request_o && reply_on) ? 6 : rep_cnt - (rep_cnt > 0);
    reply <= rep_cnt != 0;
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_errors++;
      close_out();
    end
  end
  always @(posedge clock_i) begin
    if (probe || rd_stb) begin
      got = probe ? {self_test_detail_o, switching_enable_o,
        low_side_gate_command_o, active_clamp_o, primary_fault_pin_n_o,
        alternate_report_pin_n_o} : {5'h00, rd_data};
      exp = q.pop_front();
      compares++;
      if (got !== exp) begin
        n_errors++;
        $display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
      end
    end
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clock_i);
  endtask
  task automatic wr(input logic [4:0] a, input logic [9:0] d);
    serial_host_model_inst.wr(a, d);
  endtask
  task automatic pins(input logic [4:0] p);
    q.push_back({det, p});
    probe <= 1;
    wt(1);
    probe <= 0;
  endtask
  task automatic rdc(input logic [4:0] a, input logic [9:0] e);
    q.push_back({5'h00, e});
    serial_host_model_inst.rd(a);
  endtask
  task automatic fault(input logic [10:0] f, input logic [9:0] e,
                       input logic [4:0] p);
    flt <= f;
    wt(12);
    rdc(FLAGS_ADDR, e);
    pins(p);
  endtask
  task automatic clr();
    flt <= '0;
    wt(12);
    wr(FLAGS_ADDR, 10'h3FF);
    rdc(FLAGS_ADDR, 10'h000);
    pins(5'h13);
  endtask
  task automatic close_out();
    $display("compares=%0d n_errors=%0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    r = 10'($urandom(32'h911EB854));
    wt(2);
    srst_i <= 0;
    wt(8);
    pins(5'h13);
    rdc(FLAGS_ADDR, 10'h000);
    rdc(5'h1F, 10'h000);
    fault(11'h200, 10'h080, 5'h11);
    flt <= '0;
    wt(12);
    wr(FLAGS_ADDR, 10'($urandom) & 10'h37F);
    rdc(FLAGS_ADDR, 10'h080);
    clr();
    serial_host_model_inst.frame(24'h800000, 23, rx);
    rdc(FLAGS_ADDR, 10'h040);
    clr();
    fault(11'h002, 10'h000, 5'h13);
    wr(ENABLES_ADDR, 10'h0FD);
    rdc(FLAGS_ADDR, 10'h000);
    rdc(ENABLES_ADDR, 10'h0EC);
    config_mode_i <= 1;
    wr(ENABLES_ADDR, 10'h0FD);
    config_mode_i <= 0;
    rdc(ENABLES_ADDR, 10'h0FD);
    fault(11'h002, 10'h001, 5'h0D);
    wr(FLAGS_ADDR, 10'h3FF);
    rdc(FLAGS_ADDR, 10'h001);
    clr();
    power_up_i <= 1;
    fault(11'h404, 10'h000, 5'h13);
    power_up_i <= 0;
    fault(11'h404, 10'h102, 5'h0C);
    clr();
    for (int k = 0; k < 8; k++) begin
      ce = 1'($urandom);
      active_clamp_enable_i <= ce;
      fault(11'h400 >> sh[k], fb[k], {2'h1, ce, 2'h1});
      clr();
    end
    active_clamp_enable_i <= 1;
    monitor_source_select_i <= 1;
    fault(11'h040, 10'h000, 5'h13);
    clr();
    monitor_source_select_i <= 0;
    reply_on <= 0;
    fault(11'h000, 10'h008, 5'h0D);
    reply_on <= 1;
    clr();
    config_mode_i <= 1;
    wr(ENABLES_ADDR, 10'h000);
    config_mode_i <= 0;
    reply_on <= 0;
    fault(11'h000, 10'h000, 5'h13);
    fault(11'h400, 10'h100, 5'h0D);
    reply_on <= 1;
    clr();
    r = 10'($urandom) | 10'h001;
    self_test_i <= {1'h1, r};
    wt(1);
    self_test_i <= '0;
    det = r;
    fault(11'h000, 10'h200, 5'h0D);
    rdc(SELF_TEST_ADDR, r);
    clr();
    self_test_i <= 11'h400;
    wt(1);
    self_test_i <= '0;
    det = '0;
    fault(11'h000, 10'h000, 5'h13);
    config_mode_i <= 1;
    wr(ENABLES_ADDR, 10'h0FD);
    wr(ROUTING_ADDR, 10'h3FF);
    config_mode_i <= 0;
    wr(ROUTING_ADDR, 10'h000);
    rdc(ROUTING_ADDR, 10'h083);
    fault(11'h202, 10'h081, 5'h0E);
    clr();
    close_out();
  end
endmodule

/* File: serial_host_model.sv */
// host-side serial master for the fault register port
`timescale 1ns/1ps
module serial_host_model
  import sec_fault_pkg::*;
(
  input wire logic clock_i,
  input wire logic miso_i,
  output serial_in_s serial_o,
  output logic rd_stb_o,
  output logic [DATA_W-1:0] rd_data_o
);
  initial begin
    serial_o = 3'h4;
    rd_stb_o = 1'h0;
    rd_data_o = '0;
  end
  // n bits msb first, 8 core cycles per serial clock
  task automatic frame(input logic [23:0] tx, input int n,
                       output logic [23:0] rx);
    rx = '0;
    serial_o.chip_select_n <= 1'h0;
    repeat (6) @(posedge clock_i);
    for (int i = 0; i < n; i++) begin
      serial_o.mosi <= tx[23-i];
      serial_o.sclk <= 1'h0;
      repeat (4) @(posedge clock_i);
      serial_o.sclk <= 1'h1;
      repeat (4) @(posedge clock_i);
      rx = {rx[22:0], miso_i};
    end
    serial_o.sclk <= 1'h0;
    repeat (4) @(posedge clock_i);
    // released data line must not keep a plausible level
    serial_o.chip_select_n <= 1'h1;
    serial_o.mosi <= ~serial_o.mosi;
    repeat (14) @(posedge clock_i);
  endtask
  task automatic wr(input logic [4:0] a, input logic [9:0] d);
    logic [23:0] rx;
    frame({1'h1, a, d, 8'h00}, 24, rx);
  endtask
  // answer arrives in the following frame
  task automatic rd(input logic [4:0] a);
    logic [23:0] rx;
    frame({1'h0, a, 10'h000, 8'h00}, 24, rx);
    frame({1'h0, a, 10'h000, 8'h00}, 24, rx);
    rd_data_o <= rx[17:8];
    rd_stb_o <= 1'h1;
    @(posedge clock_i);
    rd_stb_o <= 1'h0;
  endtask
endmodule
